/* File: rtl/fsf_consts.svh */
// constants for the fifo status flag and offset block
// assumes inclusion by bare name from design file and checker
`ifndef FSF_CONSTS_SVH
`define FSF_CONSTS_SVH
`define FSF_DATA_W 36
`define FSF_PTR_W 17
`define FSF_OFS_W 16
`define FSF_DEPTH 17'h10000
`define FSF_HALF 17'h08001
`define FSF_OFS_16383 16'h3FFF
`define FSF_OFS_8191 16'h1FFF
`define FSF_OFS_4095 16'h0FFF
`define FSF_OFS_2047 16'h07FF
`define FSF_OFS_1023 16'h03FF
`define FSF_OFS_511 16'h01FF
`define FSF_OFS_255 16'h00FF
`define FSF_OFS_127 16'h007F
`define FSF_REG_STATUS 8'h00
`define FSF_REG_EMPTY_OFS 8'h04
`define FSF_REG_FULL_OFS 8'h08
`define FSF_REG_SHOW 8'h0C
`endif

/* File: rtl/fsf_fifo_flags.sv */
// fifo with status flags, default and programmable offsets, wishbone offset access
// assumes one clock; write and read ports sampled synchronously to it
// Operation
// R1: fall-through input at master reset picks mode
// R2: fall-through first word out after three edges
// R3: standard empty and full doubly registered
// R4: write enable low captures input data
// R5: output-valid goes low after first write
// R6: fall-through almost-empty releases at n+2 words
// R7: fall-through half flag low at 32,770
// R8: fall-through almost-full low at 65,537-m
// R9: input-space high at 65,537, writes blocked
// R10: first read from full clears input-space
// R11: fall-through almost-empty low at n+1 words
// R12: last read raises output-valid, reads ignored
// R13: output-valid three stages, input-space two; input-space here also takes three edges after a read
// R14: parallel method defaults from select bits
// R15: serial method defaults from select bits
// R16: controller drives load method during reset
// R17: offsets read back via data output only
// R18: offsets programmable anytime, range 0 to D-1
// R19: synchronous mode flags update on own side
// R20: asynchronous mode flags released by other side
// R21: standard empty state and low-level flags
// R22: standard half flag low from 32,769
// R23: standard almost-full and full thresholds
// R24: master reset clears pointers, loads defaults
// R25: pointers cross sides gray coded
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
`include "fsf_consts.svh"
module fsf_fifo_flags
  import fsf_pkg::*;
(
  // clock, reset, enable
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  input wire logic CLK_EN_IN,
  // master reset and straps
  input wire logic MASTER_RESET_IN,
  input wire logic FALL_THROUGH_MODE_IN,
  input wire logic LOAD_METHOD_SEL_IN,
  input wire logic DEFAULT_SEL_HI_IN,
  input wire logic DEFAULT_SEL_LO_IN,
  input wire logic FLAG_TIMING_SEL_IN,
  // write port
  input wire logic WRITE_EN_N_IN,
  input wire logic [`FSF_DATA_W-1:0] DATA_IN_PORT_IN,
  // read port
  input wire logic READ_EN_N_IN,
  output logic [`FSF_DATA_W-1:0] DATA_OUT_PORT_OUT,
  // flags
  output logic EMPTY_FLAG_N_OUT,
  output logic FULL_FLAG_N_OUT,
  output logic HALF_LEVEL_N_OUT,
  output logic ALMOST_FULL_N_OUT,
  output logic ALMOST_EMPTY_N_OUT,
  output logic OUTPUT_VALID_N_OUT,
  output logic INPUT_SPACE_N_OUT,
  // wishbone slave
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT
);

  // one spare bit tells a full memory from an empty one
  typedef logic [`FSF_PTR_W-1:0] fsf_ptr_t;

  // binary to gray for pointers crossing sides
  function automatic fsf_ptr_t to_gray(input fsf_ptr_t b);
    to_gray = b ^ (b >> 1);
  endfunction

  // gray back to binary after the synchroniser
  function automatic fsf_ptr_t from_gray(input fsf_ptr_t g);
    fsf_ptr_t b;
    b[`FSF_PTR_W-1] = g[`FSF_PTR_W-1];
    for (int i = `FSF_PTR_W - 2; i >= 0; i--)
    begin
      b[i] = b[i+1] ^ g[i];
    end
    from_gray = b;
  endfunction

  // reset and caught configuration
  logic master_reset;
  logic f1;
  fsf_cfg_t cfg, next_cfg;
  // flag offsets
  logic [`FSF_OFS_W-1:0] empty_ofs, next_empty_ofs;
  logic [`FSF_OFS_W-1:0] full_ofs, next_full_ofs;
  logic [`FSF_OFS_W-1:0] dflt_ofs;
  // storage and pointers
  logic [`FSF_DATA_W-1:0] mem [0:`FSF_DEPTH-1];
  fsf_ptr_t wptr, next_wptr, wgray, next_wgray;
  fsf_ptr_t rptr, next_rptr, rgray, next_rgray;
  fsf_ptr_t cgray, next_cgray;
  logic wr_go, mem_full_w, mem_avail_r;
  // two-stage pointer synchronisers
  fsf_ptr_t wsync1, wsync2, csync1, csync2, rsync1, rsync2;
  // levels and thresholds
  fsf_ptr_t lvl_w, lvl_r;
  fsf_ptr_t paf_thr, pae_thr, half_thr, full_thr;
  // output register
  logic ov, next_ov;
  logic [`FSF_DATA_W-1:0] dout, next_dout;
  // flags and bus
  fsf_flags_t flg, next_flg;
  logic ack, next_ack;
  logic [31:0] rdat, next_rdat;
  logic bus_wr, show_e, show_f;

  // either reset restarts pointers and flags
  assign master_reset = RST_IN | MASTER_RESET_IN;
  assign f1 = cfg.fall_through_mode;

  // default offset from method and select bits
  always_comb
  begin
    case ({MASTER_RESET_IN ? LOAD_METHOD_SEL_IN : 1'b0, DEFAULT_SEL_HI_IN, DEFAULT_SEL_LO_IN})
      3'b010: dflt_ofs = `FSF_OFS_16383; // [R14]
      3'b001: dflt_ofs = `FSF_OFS_8191; // [R14]
      3'b011: dflt_ofs = `FSF_OFS_4095; // [R14]
      3'b110: dflt_ofs = `FSF_OFS_2047; // [R15]
      3'b100: dflt_ofs = `FSF_OFS_1023; // [R15]
      3'b101: dflt_ofs = `FSF_OFS_511; // [R15]
      3'b111: dflt_ofs = `FSF_OFS_255; // [R15]
      default: dflt_ofs = `FSF_OFS_127; // [R14]
    endcase
  end

  // bus decode
  assign bus_wr = WB_CYC_IN & WB_STB_IN & WB_WE_IN & ~ack;
  assign show_e = bus_wr & (WB_ADR_IN == `FSF_REG_SHOW) & WB_SEL_IN[0] & WB_DAT_IN[0];
  assign show_f = bus_wr & (WB_ADR_IN == `FSF_REG_SHOW) & WB_SEL_IN[0] & WB_DAT_IN[1];

  // configuration and offsets next values
  always_comb
  begin
    next_cfg = cfg;
    next_empty_ofs = empty_ofs;
    next_full_ofs = full_ofs;
    if (RST_IN)
    begin
      next_cfg = '0;
      next_empty_ofs = `FSF_OFS_127;
      next_full_ofs = `FSF_OFS_127;
    end
    else if (MASTER_RESET_IN)
    begin
      next_cfg.fall_through_mode = FALL_THROUGH_MODE_IN; // [R1]
      next_cfg.load_method_sel = LOAD_METHOD_SEL_IN; // [R16]
      next_cfg.flag_timing_sel = FLAG_TIMING_SEL_IN;
      next_cfg.default_sel_hi = DEFAULT_SEL_HI_IN;
      next_cfg.default_sel_lo = DEFAULT_SEL_LO_IN;
      next_empty_ofs = dflt_ofs; // [R24]
      next_full_ofs = dflt_ofs;
    end
    else if (bus_wr)
    begin
      // 16-bit field bounds every value to 0..D-1
      if (WB_ADR_IN == `FSF_REG_EMPTY_OFS)
      begin
        if (WB_SEL_IN[0]) next_empty_ofs[7:0] = WB_DAT_IN[7:0]; // [R18]
        if (WB_SEL_IN[1]) next_empty_ofs[15:8] = WB_DAT_IN[15:8];
      end
      if (WB_ADR_IN == `FSF_REG_FULL_OFS)
      begin
        if (WB_SEL_IN[0]) next_full_ofs[7:0] = WB_DAT_IN[7:0]; // [R18]
        if (WB_SEL_IN[1]) next_full_ofs[15:8] = WB_DAT_IN[15:8];
      end
    end
  end

  // configuration and offset registers
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (CLK_EN_IN)
    begin
      cfg <= next_cfg;
      empty_ofs <= next_empty_ofs;
      full_ofs <= next_full_ofs;
    end
  end

  // write side: memory room judged from synced read pointer
  assign mem_full_w = (fsf_ptr_t'(wptr - from_gray(rsync2)) == `FSF_DEPTH);
  assign wr_go = ~WRITE_EN_N_IN & ~mem_full_w & ~master_reset; // [R4] [R9]

  always_comb
  begin
    next_wptr = wptr;
    if (master_reset) next_wptr = '0; // [R24]
    else if (wr_go) next_wptr = fsf_ptr_t'(wptr + 1'b1);
    next_wgray = to_gray(next_wptr); // [R25]
  end

  // write pointer and memory write
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (CLK_EN_IN)
    begin
      wptr <= next_wptr;
      wgray <= next_wgray;
      if (wr_go) mem[wptr[`FSF_PTR_W-2:0]] <= DATA_IN_PORT_IN; // [R4]
    end
  end

  // pointer synchronisers in both directions
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (CLK_EN_IN)
    begin
      if (master_reset)
      begin
        wsync1 <= '0;
        wsync2 <= '0;
        csync1 <= '0;
        csync2 <= '0;
        rsync1 <= '0;
        rsync2 <= '0;
      end
      else
      begin
        wsync1 <= wgray; // [R25]
        wsync2 <= wsync1;
        csync1 <= cgray;
        csync2 <= csync1;
        rsync1 <= rgray;
        rsync2 <= rsync1;
      end
    end
  end

  // read side: standard reads on request, fall-through preloads output
  assign mem_avail_r = (from_gray(wsync2) != rptr);

  always_comb
  begin
    next_rptr = rptr;
    next_ov = ov;
    next_dout = dout;
    if (master_reset)
    begin
      next_rptr = '0; // [R24]
      next_ov = 1'b0;
      next_dout = '0;
    end
    else if (f1)
    begin
      if (mem_avail_r && (!ov || !READ_EN_N_IN))
      begin
        next_dout = mem[rptr[`FSF_PTR_W-2:0]]; // [R2]
        next_rptr = fsf_ptr_t'(rptr + 1'b1);
        next_ov = 1'b1;
      end
      else if (ov && !READ_EN_N_IN)
        next_ov = 1'b0; // [R12]
    end
    else if (!READ_EN_N_IN && mem_avail_r)
    begin
      next_dout = mem[rptr[`FSF_PTR_W-2:0]]; // [R12]
      next_rptr = fsf_ptr_t'(rptr + 1'b1);
    end
    if (!master_reset && show_e) next_dout = {{(`FSF_DATA_W-`FSF_OFS_W){1'b0}}, empty_ofs}; // [R17]
    else if (!master_reset && show_f) next_dout = {{(`FSF_DATA_W-`FSF_OFS_W){1'b0}}, full_ofs}; // [R17]
    next_rgray = to_gray(next_rptr); // [R25]
    next_cgray = to_gray(fsf_ptr_t'(next_rptr - {{(`FSF_PTR_W-1){1'b0}}, next_ov})); // [R25]
  end

  // read pointer, output word and gray copies
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (CLK_EN_IN)
    begin
      rptr <= next_rptr;
      ov <= next_ov;
      dout <= next_dout;
      rgray <= next_rgray;
      cgray <= next_cgray;
    end
  end

  // data pins straight from the output register
  assign DATA_OUT_PORT_OUT = dout;

  // levels and thresholds; fall-through counts the output word
  assign lvl_w = fsf_ptr_t'(wptr - from_gray(csync2));
  assign lvl_r = fsf_ptr_t'(from_gray(wsync2) - from_gray(cgray));
  assign full_thr = fsf_ptr_t'(`FSF_DEPTH + f1);
  assign half_thr = fsf_ptr_t'(`FSF_HALF + f1);
  assign paf_thr = fsf_ptr_t'(`FSF_DEPTH + f1 - full_ofs);
  assign pae_thr = fsf_ptr_t'(empty_ofs + f1);

  // flag next values
  always_comb
  begin
    next_flg = flg;
    if (master_reset)
    begin
      next_flg = '1; // [R24] [R21]
      next_flg.empty_flag_n = 1'b0;
      next_flg.almost_empty_n = 1'b0;
      next_flg.input_space_n = 1'b0;
    end
    else
    begin
      next_flg.empty_flag_n = f1 | mem_avail_r; // [R3] [R21]
      next_flg.full_flag_n = f1 | (lvl_w != full_thr); // [R3] [R23]
      next_flg.input_space_n = f1 & (lvl_w == full_thr); // [R9] [R10] [R13]
      next_flg.output_valid_n = ~(f1 & next_ov); // [R5] [R12] [R13]
      next_flg.half_level_n = ~(lvl_w >= half_thr); // [R7] [R22]
      if (cfg.flag_timing_sel)
      begin
        next_flg.almost_full_n = ~(lvl_w >= paf_thr); // [R19] [R8] [R23]
        next_flg.almost_empty_n = ~(lvl_r <= pae_thr); // [R19] [R6] [R11]
      end
      else
      begin
        // asserted on own side, released on the opposite side
        next_flg.almost_full_n = flg.almost_full_n ? ~(lvl_w >= paf_thr) : ~(lvl_r >= paf_thr); // [R20]
        next_flg.almost_empty_n = flg.almost_empty_n ? ~(lvl_r <= pae_thr) : ~(lvl_w <= pae_thr); // [R20]
      end
    end
  end

  // flag register
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (CLK_EN_IN) flg <= next_flg;
  end

  // flag pins straight from the flag register
  assign EMPTY_FLAG_N_OUT = flg.empty_flag_n;
  assign FULL_FLAG_N_OUT = flg.full_flag_n;
  assign HALF_LEVEL_N_OUT = flg.half_level_n;
  assign ALMOST_FULL_N_OUT = flg.almost_full_n;
  assign ALMOST_EMPTY_N_OUT = flg.almost_empty_n;
  assign OUTPUT_VALID_N_OUT = flg.output_valid_n;
  assign INPUT_SPACE_N_OUT = flg.input_space_n;

  // wishbone answer: one cycle after request, offsets write-only
  always_comb
  begin
    next_ack = 1'b0;
    next_rdat = '0;
    if (!RST_IN && WB_CYC_IN && WB_STB_IN && !ack)
    begin
      next_ack = 1'b1;
      if (!WB_WE_IN && WB_ADR_IN == `FSF_REG_STATUS)
        next_rdat = {20'h00000, fsf_status_t'({cfg, flg})};
    end
  end

  // bus answer registers
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (CLK_EN_IN)
    begin
      ack <= next_ack;
      rdat <= next_rdat;
    end
  end

  // bus pins
  assign WB_ACK_OUT = ack;
  assign WB_DAT_OUT = rdat;

endmodule

/* File: rtl/fsf_pkg.sv */
// types for the fifo status flag and offset block
// assumes fsf_consts.svh is on the include path
package fsf_pkg;
  // configuration caught during master reset
  typedef struct packed {
    logic fall_through_mode;
    logic load_method_sel;
    logic flag_timing_sel;
    logic default_sel_hi;
    logic default_sel_lo;
  } fsf_cfg_t;
  // active-low flag set
  typedef struct packed {
    logic input_space_n;
    logic output_valid_n;
    logic almost_empty_n;
    logic almost_full_n;
    logic half_level_n;
    logic full_flag_n;
    logic empty_flag_n;
  } fsf_flags_t;
  // status word seen over the bus
  typedef struct packed {
    fsf_cfg_t cfg;
    fsf_flags_t flags;
  } fsf_status_t;
endpackage

/* File: test/fsf_fifo_flags_checker.sv */
// pin assertions for the fifo flag block
// assumes binding onto fsf_fifo_flags, one clock domain
`timescale 1ns/100ps
`include "fsf_consts.svh"
module fsf_fifo_flags_checker
  import fsf_pkg::*;
(
  // clock, resets, mode strap
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  input wire logic MASTER_RESET_IN,
  input wire logic FALL_THROUGH_MODE_IN,
  // data path
  input wire logic WRITE_EN_N_IN,
  input wire logic [`FSF_DATA_W-1:0] DATA_IN_PORT_IN,
  input wire logic [`FSF_DATA_W-1:0] DATA_OUT_PORT_OUT,
  // flags
  input wire logic EMPTY_FLAG_N_OUT,
  input wire logic FULL_FLAG_N_OUT,
  input wire logic HALF_LEVEL_N_OUT,
  input wire logic ALMOST_FULL_N_OUT,
  input wire logic ALMOST_EMPTY_N_OUT,
  input wire logic OUTPUT_VALID_N_OUT,
  input wire logic INPUT_SPACE_N_OUT,
  // bus
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [31:0] WB_DAT_OUT,
  input wire logic WB_ACK_OUT
);
  default clocking @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (RST_IN);
  logic fall_through_mode_q;
  logic next_fall_through_mode_q;
  wire [6:0] flg = {INPUT_SPACE_N_OUT, OUTPUT_VALID_N_OUT, ALMOST_EMPTY_N_OUT, ALMOST_FULL_N_OUT,
    HALF_LEVEL_N_OUT, FULL_FLAG_N_OUT, EMPTY_FLAG_N_OUT};
  // mode caught while master reset is high
  always_comb next_fall_through_mode_q = RST_IN ? 1'b0 : MASTER_RESET_IN ? FALL_THROUGH_MODE_IN : fall_through_mode_q;
  always_ff @(posedge SYS_CLK_IN) fall_through_mode_q <= next_fall_through_mode_q;
  sequence empty_idle_s;
    (WRITE_EN_N_IN && OUTPUT_VALID_N_OUT && !MASTER_RESET_IN)[*4];
  endsequence
  sequence first_write_s;
    fall_through_mode_q && !WRITE_EN_N_IN && !MASTER_RESET_IN;
  endsequence
  ack_pulse_a: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("bus ack held too long");
  ack_delay_a: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT)
    else $error("bus ack late");
  read_zero_a: assert property (WB_ACK_OUT && !$past(WB_WE_IN) && $past(WB_ADR_IN) != 8'h00 |-> WB_DAT_OUT == 32'h0)
    else $error("offset or unmapped read not zero");
  reset_state_a: assert property (MASTER_RESET_IN |=> flg == 7'h2E)
    else $error("flags wrong after master reset");
  std_quiet_a: assert property (!fall_through_mode_q |-> OUTPUT_VALID_N_OUT && !INPUT_SPACE_N_OUT)
    else $error("fall-through flags active in standard mode");
  fall_through_mode_pins_a: assert property ((fall_through_mode_q && !MASTER_RESET_IN)[*4] |-> EMPTY_FLAG_N_OUT && FULL_FLAG_N_OUT)
    else $error("standard flags active in fall-through mode");
  first_word_a: assert property (empty_idle_s ##1 first_write_s |-> ##3 OUTPUT_VALID_N_OUT
    ##1 (!OUTPUT_VALID_N_OUT && DATA_OUT_PORT_OUT == $past(DATA_IN_PORT_IN, 4)))
    else $error("first word latency wrong");
  empty_hold_a: assert property ((!fall_through_mode_q && WRITE_EN_N_IN && !EMPTY_FLAG_N_OUT)[*8] |=> !EMPTY_FLAG_N_OUT)
    else $error("empty flag left without a write");
endmodule
bind fsf_fifo_flags fsf_fifo_flags_checker i_chk (.*);

/* File: test/fsf_side_model.sv */
// writer and reader standing on the far side of the fifo
// assumes commands change by nonblocking assignment at rising edges
`timescale 1ns/100ps
module fsf_side_model
(
  // clock and commands
  input wire logic clk_in,
  input wire logic do_wr_in,
  input wire logic do_rd_in,
  // fifo side
  output logic wen_n_out,
  output logic ren_n_out,
  output logic [35:0] din_out,
  output logic [35:0] last_out
);
  logic [63:0] r;
  // idle levels at time zero
  initial
  begin
    wen_n_out = 1'b1;
    ren_n_out = 1'b1;
    din_out = 36'h0;
  end
  // one enable cycle per word, idle data keeps changing
  always @(posedge clk_in)
  begin
    r = {$urandom, $urandom};
    wen_n_out <= !do_wr_in;
    ren_n_out <= !do_rd_in;
    din_out <= do_wr_in ? r[35:0] : ~din_out;
    if (do_wr_in)
      last_out <= r[35:0];
  end
endmodule

/* File: test/test_fsf_fifo_flags.sv */
// self-checking bench for the fifo flag block
// assumes side model and checker are compiled first
`timescale 1ns/100ps
module test_fsf_fifo_flags;
  import fsf_pkg::*;
  logic clk = 0, rst = 1, master_reset = 0, fw = 0, ld = 0, hi = 0, lo = 0, tim = 0;
  logic do_wr = 0, do_rd = 0, cyc = 0, stb = 0, we = 0, ce = 1, wen, ren, ack;
  logic [7:0] adr = 0;
  logic [4:0] cf;
  logic [31:0] wd = 0, rd, m;
  logic [35:0] din, dout, lw;
  logic [31:0] eq[$], mq[$];
  int n_mismatch = 0, samples_checked = 0, cnt = 0;
  int tbl[8] = '{127, 8191, 16383, 4095, 1023, 511, 2047, 255};
  always #5 clk = ~clk;
  fsf_side_model i_side (.clk_in(clk), .do_wr_in(do_wr), .do_rd_in(do_rd), .wen_n_out(wen), .ren_n_out(ren),
    .din_out(din), .last_out(lw));
  fsf_fifo_flags i_dut (.SYS_CLK_IN(clk), .RST_IN(rst), .CLK_EN_IN(ce), .MASTER_RESET_IN(master_reset),
    .FALL_THROUGH_MODE_IN(fw), .LOAD_METHOD_SEL_IN(ld), .DEFAULT_SEL_HI_IN(hi), .DEFAULT_SEL_LO_IN(lo),
    .FLAG_TIMING_SEL_IN(tim), .WRITE_EN_N_IN(wen), .DATA_IN_PORT_IN(din), .READ_EN_N_IN(ren),
    .DATA_OUT_PORT_OUT(dout), .EMPTY_FLAG_N_OUT(), .FULL_FLAG_N_OUT(), .HALF_LEVEL_N_OUT(),
    .ALMOST_FULL_N_OUT(), .ALMOST_EMPTY_N_OUT(), .OUTPUT_VALID_N_OUT(), .INPUT_SPACE_N_OUT(),
    .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hF), .WB_DAT_IN(wd),
    .WB_DAT_OUT(rd), .WB_ACK_OUT(ack));
  task give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task cmp(input string nm, input logic [35:0] s, input logic [35:0] e);
    samples_checked++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    while (ack !== 1'b1)
      @(posedge clk);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task rq(input logic [7:0] a, input logic [31:0] e, input logic [31:0] mk);
    eq.push_back(e);
    mq.push_back(mk);
    bus(a, 1'b0, 32'h0);
  endtask
  task fl(input int b, input logic v);
    rq(8'h00, 32'(v) << b, 32'h1 << b);
  endtask
  task show(input logic [1:0] s, input int e);
    bus(8'h0C, 1'b1, {30'h0, s});
    #1 cmp("offset", dout, 36'(e));
  endtask
  task mr(input logic [4:0] c);
    @(posedge clk);
    {fw, ld, tim, hi, lo} <= c;
    master_reset <= 1'b1;
    repeat (2) @(posedge clk);
    master_reset <= 1'b0;
    cnt = 0;
    repeat (4) @(posedge clk);
  endtask
  task mv(input logic w, input int k);
    @(posedge clk);
    do_wr <= w;
    do_rd <= !w;
    repeat (k) @(posedge clk);
    do_wr <= 1'b0;
    do_rd <= 1'b0;
    repeat (8) @(posedge clk);
    cnt += w ? k : -k;
  endtask
  task fill(input int t);
    mv(1'b1, t - cnt);
  endtask
  // bus read results against the oldest note
  always @(posedge clk)
    if (ack === 1'b1 && we === 1'b0 && eq.size() > 0)
    begin
      m = mq.pop_front();
      cmp("bus read", rd & m, eq.pop_front() & m);
    end
  // hang guard
  initial
  begin
    #900000;
    n_mismatch++;
    give_verdict();
  end
  initial
  begin
    void'($urandom(32'hA18CE96C));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // default offsets for each strap pattern
    for (int i = 0; i < 8; i++)
    begin
      cf = {1'b0, i[2], 1'($urandom), i[1:0]};
      mr(cf);
      rq(8'h00, {20'h0, cf, 7'h2E}, 32'hFFF);
      show(2'b01, tbl[i]);
      show(2'b10, tbl[i]);
    end
    rq(8'h10, 32'h0, 32'hFFFFFFFF);
    // standard mode, asynchronous almost flags, small empty offset
    mr(5'h00);
    bus(8'h04, 1'b1, 32'h3);
    show(2'b01, 3);
    mv(1'b1, 3);
    fl(0, 1'b1);
    fl(4, 1'b0);
    mv(1'b1, 1);
    fl(4, 1'b1);
    mv(1'b0, 6);
    cmp("read word", dout, lw);
    fl(0, 1'b0);
    // writes while the clock enable is low must be dropped
    ce <= 1'b0;
    mv(1'b1, 2);
    ce <= 1'b1;
    fl(0, 1'b0);
    mv(1'b1, 1);
    fl(0, 1'b1);
    // fall-through mode, first word then full fill
    mr(5'h14);
    bus(8'h04, 1'b1, 32'h3);
    mv(1'b1, 1);
    cmp("first word", dout, lw);
    fl(5, 1'b0);
    mv(1'b0, 2);
    fl(5, 1'b1);
    cnt = 0;
    mv(1'b1, 4);
    fl(4, 1'b0);
    mv(1'b1, 1);
    fl(4, 1'b1);
    mv(1'b0, 1);
    fl(4, 1'b0);
    bus(8'h08, 1'b1, 32'h64);
    fill(32769);
    fl(2, 1'b1);
    mv(1'b1, 1);
    fl(2, 1'b0);
    fill(65436);
    fl(3, 1'b1);
    mv(1'b1, 1);
    fl(3, 1'b0);
    fill(65536);
    fl(6, 1'b0);
    mv(1'b1, 3);
    fl(6, 1'b1);
    mv(1'b0, 1);
    fl(6, 1'b0);
    mv(1'b0, 100);
    fl(3, 1'b1);
    repeat (2) @(posedge clk);
    cmp("pending reads", 36'(eq.size()), 36'h0);
    give_verdict();
  end
endmodule
